// ===== sfq_regs.svh
// Opcodes, field values and phase lengths of the flash read engine
`ifndef SFQ_REGS_SVH
`define SFQ_REGS_SVH

// Read opcodes and continuous-mode release code
`define SFQ_OP_FAST_RD       8'h0b
`define SFQ_OP_FAST_RD_4B    8'h0c
`define SFQ_OP_QOUT_RD       8'h6b
`define SFQ_OP_QOUT_RD_4B    8'h6c
`define SFQ_OP_QIO_RD        8'heb
`define SFQ_OP_QIO_RD_4B     8'hec
`define SFQ_OP_CONT_RELEASE  8'hff

// Mode byte upper nibble that keeps continuous reads
`define SFQ_MODE_KEEP_NIB    4'ha

// Phase lengths in bits
`define SFQ_OPC_BITS         6'h08
`define SFQ_ADDR3_BITS       6'h18
`define SFQ_ADDR4_BITS       6'h20
`define SFQ_MODE_BITS        6'h08

// Data shifter
`define SFQ_SINGLE_LEFT      3'h7
`define SFQ_QUAD_LEFT        3'h1
`define SFQ_OE_SINGLE        4'h2
`define SFQ_OE_QUAD          4'hf
`define SFQ_OE_OFF           4'h0
`define SFQ_UNDERRUN_BYTE    8'hff

`endif

// ===== sfq_pkg.sv
// Types shared by the flash read engine files
package sfq_pkg;

   typedef enum logic [2:0] {
      SFQ_ST_IDLE   = 3'b000,
      SFQ_ST_OPC    = 3'b001,
      SFQ_ST_ADDR   = 3'b010,
      SFQ_ST_MODE   = 3'b011,
      SFQ_ST_DUMMY  = 3'b100,
      SFQ_ST_DATA   = 3'b101,
      SFQ_ST_IGNORE = 3'b110
   } sfq_state_t;

   // Static configuration bits
   typedef struct packed {
      logic       all_four_line_command_mode;
      logic       four_line_allow;
      logic       quad_en;
      logic       addr4;
      logic [3:0] latency;
   } sfq_cfg_t;

   // Shape of one read frame
   typedef struct packed {
      logic addr_quad;
      logic data_quad;
      logic has_mode;
      logic addr4;
   } sfq_rd_t;

   // Array read answer
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } sfq_rsp_t;

endpackage

// ===== sfq_fifo2.sv
// Small flushable FIFO between array fetch and serial shifter
`timescale 1ns/100ps
module sfq_fifo2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             flush_i,
   // Fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // Drain side
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PW-1:0]    rd_reg;
   logic [PW-1:0]    rd_next;
   logic [PW-1:0]    wr_reg;
   logic [PW-1:0]    wr_next;
   logic [PW:0]      cnt_reg;
   logic [PW:0]      cnt_next;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   assign in_ready_o  = (cnt_reg < (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = store_reg[rd_reg];
   assign push        = in_valid_i && in_ready_o && !flush_i;
   assign pop         = out_valid_o && out_ready_i && !flush_i;

   always_comb begin
      rd_next  = pop ? bump(rd_reg) : rd_reg;
      wr_next  = push ? bump(wr_reg) : wr_reg;
      cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
      if (flush_i) begin
         rd_next  = '0;
         wr_next  = '0;
         cnt_next = '0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_reg  <= '0;
         wr_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         rd_reg  <= rd_next;
         wr_reg  <= wr_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage needs no reset; count guards reads
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         store_reg[wr_reg] <= in_data_i;
      end
   end

endmodule

// ===== sfq_read_engine.sv
// Serial flash fast, quad output and quad I/O read engine
//
// Functional notes
// - 0Bh length per bit; 0Ch four bytes
// - 6Bh length per bit; 6Ch four bytes
// - EBh length per bit; ECh four bytes
// - Dummy count from latency code field
// - Data lines ignored during dummy cycles
// - Data driven on falling edges, 1/4 lines
// - Address increments per byte, wraps to zero only at the ADDR_W-bit top, not at the 3-byte end
// - Only upper mode nibble is decoded
// - Nibble A keeps continuous mode, no opcode
// - Other nibble leaves continuous mode at deselect
// - Release command also leaves continuous mode
// - Quad I/O address four bits per clock
// - Quad I/O mode byte two clocks, then dummies
// - Quad I/O needs quad enable or four-line allow
// - Quad output needs quad enable, not command mode
// - Quad output address on line 0 only
// - Four-line command mode sends opcodes 4-wide
// - There quad I/O codes act as fast reads
// - Address length bit widens 3-byte commands
// - Opcode one bit per rise, four in four-line command mode; deselect ends read
// - Dummies counted fall to fall; zero allowed
`timescale 1ns/100ps
`include "sfq_regs.svh"
module sfq_read_engine #(
   parameter int ADDR_W     = 32,
   parameter int FIFO_DEPTH = 2
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              sys_rst_i,
   // Serial link pins
   input  wire logic              sck_i,
   input  wire logic              cs_n_i,
   input  wire logic [3:0]        io_i,
   output logic [3:0]             io_o,
   output logic [3:0]             io_oe_o,
   // Configuration
   input  wire sfq_pkg::sfq_cfg_t cfg_i,
   // Array read port
   output logic                   mem_req_o,
   output logic [ADDR_W-1:0]      mem_addr_o,
   input  wire sfq_pkg::sfq_rsp_t mem_rsp_i,
   // Status
   output logic                   continuous_read_mode_o,
   output logic                   reading_o
);

   // Pin synchronisers
   logic       sck_s1;
   logic       sck_s2;
   logic       sck_s3;
   logic       cs_s1;
   logic       cs_s2;
   logic       cs_s3;
   logic [3:0] io_s1;
   logic [3:0] io_s2;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_s3  <= 1'b1;
         io_s1  <= 4'h0;
         io_s2  <= 4'h0;
      end else begin
         sck_s1 <= sck_i;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         cs_s1  <= cs_n_i;
         cs_s2  <= cs_s1;
         cs_s3  <= cs_s2;
         io_s1  <= io_i;
         io_s2  <= io_s1;
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_fall;

   // Clock edges only count while selected
   assign sck_rise = sck_s2 && !sck_s3 && !cs_s2;
   assign sck_fall = !sck_s2 && sck_s3 && !cs_s2;
   assign cs_rise  = cs_s2 && !cs_s3;
   assign cs_fall  = !cs_s2 && cs_s3;

   function automatic logic [31:0] shift_in(input logic [31:0] sh,
                                            input logic [3:0]  io,
                                            input logic        quad);
      shift_in = quad ? {sh[27:0], io} : {sh[30:0], io[0]};
   endfunction

   // Rising edges needed for a field of the given bit length
   function automatic logic [5:0] steps(input logic [5:0] bits,
                                        input logic       quad);
      steps = quad ? {2'h0, bits[5:2]} : bits;
   endfunction

   function automatic sfq_pkg::sfq_rd_t mk_rd(input logic aq,
                                              input logic dq,
                                              input logic hm,
                                              input logic a4);
      mk_rd.addr_quad = aq;
      mk_rd.data_quad = dq;
      mk_rd.has_mode  = hm;
      mk_rd.addr4     = a4;
   endfunction

   function automatic logic [5:0] addr_steps(input sfq_pkg::sfq_rd_t rd);
      addr_steps = steps(rd.addr4 ? `SFQ_ADDR4_BITS : `SFQ_ADDR3_BITS,
                         rd.addr_quad);
   endfunction

   // Serial engine state
   sfq_pkg::sfq_state_t state_reg;
   sfq_pkg::sfq_state_t state_next;
   sfq_pkg::sfq_rd_t    rd_reg;
   sfq_pkg::sfq_rd_t    rd_next;
   sfq_pkg::sfq_rd_t    cont_rd_reg;
   sfq_pkg::sfq_rd_t    cont_rd_next;
   logic [5:0]          cnt_reg;
   logic [5:0]          cnt_next;
   logic [31:0]         sh_reg;
   logic [31:0]         sh_next;
   logic [3:0]          dummy_reg;
   logic [3:0]          dummy_next;
   logic [7:0]          dbyte_reg;
   logic [7:0]          dbyte_next;
   logic [2:0]          dleft_reg;
   logic [2:0]          dleft_next;
   logic [3:0]          io_reg;
   logic [3:0]          io_next;
   logic [3:0]          oe_reg;
   logic [3:0]          oe_next;
   logic                mode_done_reg;
   logic                mode_done_next;
   logic                mode_keep_reg;
   logic                mode_keep_next;
   logic                cont_reg;
   logic                cont_next;
   logic                reading_reg;
   logic                reading_next;

   // Between engine, fetcher and buffer
   logic                start_fetch;
   logic [ADDR_W-1:0]   start_addr;
   logic                pop;
   logic                fifo_out_valid;
   logic [7:0]          fifo_out_data;
   logic                fifo_in_ready;
   logic                push;

   logic [31:0]         sh_in;
   logic                quad_in;
   logic [7:0]          op;
   logic                op_ok;
   sfq_pkg::sfq_rd_t    op_rd;
   logic                drive_now;
   logic [7:0]          byte_now;

   always_comb begin
      state_next     = state_reg;
      rd_next        = rd_reg;
      cont_rd_next   = cont_rd_reg;
      cnt_next       = cnt_reg;
      sh_next        = sh_reg;
      dummy_next     = dummy_reg;
      dbyte_next     = dbyte_reg;
      dleft_next     = dleft_reg;
      io_next        = io_reg;
      oe_next        = oe_reg;
      mode_done_next = mode_done_reg;
      mode_keep_next = mode_keep_reg;
      cont_next      = cont_reg;
      start_fetch    = 1'b0;
      start_addr     = '0;
      pop            = 1'b0;
      drive_now      = 1'b0;
      byte_now       = `SFQ_UNDERRUN_BYTE;
      op_ok          = 1'b0;
      op_rd          = '0;
      quad_in = (state_reg == sfq_pkg::SFQ_ST_OPC)
                ? cfg_i.all_four_line_command_mode : rd_reg.addr_quad;
      sh_in   = shift_in(sh_reg, io_s2, quad_in);
      op      = sh_in[7:0];

      if (cfg_i.all_four_line_command_mode) begin
         // quad I/O codes decode as fast reads
         if (op == `SFQ_OP_FAST_RD || op == `SFQ_OP_QIO_RD) begin
            op_ok = 1'b1;
            op_rd = mk_rd(1'b1, 1'b1, 1'b1, cfg_i.addr4);
         end else if (op == `SFQ_OP_FAST_RD_4B ||
                      op == `SFQ_OP_QIO_RD_4B) begin
            op_ok = 1'b1;
            op_rd = mk_rd(1'b1, 1'b1, 1'b1, 1'b1);
         end
      end else begin
         if (op == `SFQ_OP_FAST_RD || op == `SFQ_OP_FAST_RD_4B) begin
            op_ok = 1'b1;
            op_rd = mk_rd(1'b0, 1'b0, 1'b1,
                          cfg_i.addr4 || op == `SFQ_OP_FAST_RD_4B);
         // quad output gated by quad enable
         end else if (cfg_i.quad_en && (op == `SFQ_OP_QOUT_RD ||
                                        op == `SFQ_OP_QOUT_RD_4B)) begin
            op_ok = 1'b1;
            op_rd = mk_rd(1'b0, 1'b1, 1'b0,
                          cfg_i.addr4 || op == `SFQ_OP_QOUT_RD_4B);
         // quad I/O gated by either enable
         end else if ((cfg_i.quad_en || cfg_i.four_line_allow) &&
                      (op == `SFQ_OP_QIO_RD ||
                       op == `SFQ_OP_QIO_RD_4B)) begin
            op_ok = 1'b1;
            op_rd = mk_rd(1'b1, 1'b1, 1'b1,
                          cfg_i.addr4 || op == `SFQ_OP_QIO_RD_4B);
         end
      end

      case (state_reg)
         sfq_pkg::SFQ_ST_IDLE: begin
            if (cs_fall) begin
               sh_next = '0;
               if (cont_reg) begin
                  rd_next    = cont_rd_reg;
                  cnt_next   = addr_steps(cont_rd_reg);
                  state_next = sfq_pkg::SFQ_ST_ADDR;
               end else begin
                  cnt_next   = steps(`SFQ_OPC_BITS,
                                     cfg_i.all_four_line_command_mode);
                  state_next = sfq_pkg::SFQ_ST_OPC;
               end
            end
         end
         sfq_pkg::SFQ_ST_OPC: begin
            if (sck_rise) begin
               sh_next  = sh_in;
               cnt_next = cnt_reg - 6'h01;
               if (cnt_reg == 6'h01) begin
                  if (op_ok) begin
                     rd_next    = op_rd;
                     cnt_next   = addr_steps(op_rd);
                     state_next = sfq_pkg::SFQ_ST_ADDR;
                  end else begin
                     if (op == `SFQ_OP_CONT_RELEASE) begin
                        cont_next = 1'b0;
                     end
                     state_next = sfq_pkg::SFQ_ST_IGNORE;
                  end
               end
            end
         end
         sfq_pkg::SFQ_ST_ADDR: begin
            // quad I/O address shifts four bits
            // quad output address on line 0
            if (sck_rise) begin
               sh_next  = sh_in;
               cnt_next = cnt_reg - 6'h01;
               if (cnt_reg == 6'h01) begin
                  // 3-byte field drops the upper byte
                  start_fetch = 1'b1;
                  start_addr  = rd_reg.addr4 ? ADDR_W'(sh_in)
                                             : ADDR_W'(sh_in[23:0]);
                  sh_next     = '0;
                  dummy_next  = cfg_i.latency;
                  if (rd_reg.has_mode) begin
                     // mode byte two clocks when quad
                     cnt_next   = steps(`SFQ_MODE_BITS, rd_reg.addr_quad);
                     state_next = sfq_pkg::SFQ_ST_MODE;
                  end else begin
                     state_next = sfq_pkg::SFQ_ST_DUMMY;
                  end
               end
            end
         end
         sfq_pkg::SFQ_ST_MODE: begin
            if (sck_rise) begin
               sh_next  = sh_in;
               cnt_next = cnt_reg - 6'h01;
               if (cnt_reg == 6'h01) begin
                  // lower nibble is never looked at
                  mode_done_next = 1'b1;
                  mode_keep_next = (sh_in[7:4] == `SFQ_MODE_KEEP_NIB);
                  state_next     = sfq_pkg::SFQ_ST_DUMMY;
               end
            end
         end
         sfq_pkg::SFQ_ST_DUMMY: begin
            // counted fall to fall, zero allowed
            if (sck_fall) begin
               if (dummy_reg == 4'h0) begin
                  drive_now  = 1'b1;
                  state_next = sfq_pkg::SFQ_ST_DATA;
               end else begin
                  dummy_next = dummy_reg - 4'h1;
               end
            end
         end
         sfq_pkg::SFQ_ST_DATA: begin
            drive_now = sck_fall;
         end
         default: begin
            state_next = state_reg;
         end
      endcase

      // one or four bits per falling edge
      if (drive_now) begin
         oe_next = rd_reg.data_quad ? `SFQ_OE_QUAD : `SFQ_OE_SINGLE;
         if (dleft_reg == 3'h0) begin
            pop      = 1'b1;
            byte_now = fifo_out_valid ? fifo_out_data : `SFQ_UNDERRUN_BYTE;
         end else begin
            byte_now = dbyte_reg;
         end
         if (rd_reg.data_quad) begin
            io_next    = byte_now[7:4];
            dbyte_next = {byte_now[3:0], 4'h0};
            dleft_next = (dleft_reg == 3'h0) ? `SFQ_QUAD_LEFT
                                             : dleft_reg - 3'h1;
         end else begin
            io_next    = {2'h0, byte_now[7], 1'b0};
            dbyte_next = {byte_now[6:0], 1'b0};
            dleft_next = (dleft_reg == 3'h0) ? `SFQ_SINGLE_LEFT
                                             : dleft_reg - 3'h1;
         end
      end

      if (cs_rise) begin
         state_next     = sfq_pkg::SFQ_ST_IDLE;
         io_next        = 4'h0;
         oe_next        = `SFQ_OE_OFF;
         dleft_next     = 3'h0;
         mode_done_next = 1'b0;
         pop            = 1'b0;
         // any other nibble leaves it here
         if (mode_done_reg) begin
            cont_next    = mode_keep_reg;
            cont_rd_next = rd_reg;
         end
         // release code sent where an address is due
         // Replayed frames skip the opcode, so look at the address bits
         if (state_reg == sfq_pkg::SFQ_ST_ADDR &&
             sh_reg[7:0] == `SFQ_OP_CONT_RELEASE) begin
            cont_next = 1'b0;
         end
      end
      reading_next = (state_next == sfq_pkg::SFQ_ST_DATA);
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg     <= sfq_pkg::SFQ_ST_IDLE;
         rd_reg        <= '0;
         cont_rd_reg   <= '0;
         cnt_reg       <= 6'h00;
         sh_reg        <= 32'h0000_0000;
         dummy_reg     <= 4'h0;
         dbyte_reg     <= 8'h00;
         dleft_reg     <= 3'h0;
         io_reg        <= 4'h0;
         oe_reg        <= `SFQ_OE_OFF;
         mode_done_reg <= 1'b0;
         mode_keep_reg <= 1'b0;
         cont_reg      <= 1'b0;
         reading_reg   <= 1'b0;
      end else begin
         state_reg     <= state_next;
         rd_reg        <= rd_next;
         cont_rd_reg   <= cont_rd_next;
         cnt_reg       <= cnt_next;
         sh_reg        <= sh_next;
         dummy_reg     <= dummy_next;
         dbyte_reg     <= dbyte_next;
         dleft_reg     <= dleft_next;
         io_reg        <= io_next;
         oe_reg        <= oe_next;
         mode_done_reg <= mode_done_next;
         mode_keep_reg <= mode_keep_next;
         cont_reg      <= cont_next;
         reading_reg   <= reading_next;
      end
   end

   // Array prefetch, one request in flight
   logic              fetch_on_reg;
   logic              fetch_on_next;
   logic [ADDR_W-1:0] faddr_reg;
   logic [ADDR_W-1:0] faddr_next;
   logic              req_reg;
   logic              req_next;
   logic [ADDR_W-1:0] maddr_reg;
   logic [ADDR_W-1:0] maddr_next;
   logic              pend_reg;
   logic              pend_next;
   logic              stale_reg;
   logic              stale_next;

   // Answer to a request from an ended frame is dropped
   assign push = mem_rsp_i.valid && !stale_reg;

   always_comb begin
      fetch_on_next = fetch_on_reg;
      faddr_next    = faddr_reg;
      req_next      = 1'b0;
      maddr_next    = maddr_reg;
      pend_next     = pend_reg;
      stale_next    = stale_reg;
      if (mem_rsp_i.valid) begin
         pend_next  = 1'b0;
         stale_next = 1'b0;
      end
      if (cs_rise) begin
         fetch_on_next = 1'b0;
         if (pend_reg && !mem_rsp_i.valid) begin
            stale_next = 1'b1;
         end
      end else if (start_fetch) begin
         fetch_on_next = 1'b1;
         faddr_next    = start_addr;
      end else if (fetch_on_reg && !pend_reg && !push && fifo_in_ready) begin
         req_next   = 1'b1;
         maddr_next = faddr_reg;
         // natural wrap of the counter to zero
         faddr_next = faddr_reg + ADDR_W'(1);
         pend_next  = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fetch_on_reg <= 1'b0;
         faddr_reg    <= '0;
         req_reg      <= 1'b0;
         maddr_reg    <= '0;
         pend_reg     <= 1'b0;
         stale_reg    <= 1'b0;
      end else begin
         fetch_on_reg <= fetch_on_next;
         faddr_reg    <= faddr_next;
         req_reg      <= req_next;
         maddr_reg    <= maddr_next;
         pend_reg     <= pend_next;
         stale_reg    <= stale_next;
      end
   end

   // Buffer absorbs array latency; full stalls prefetch
   sfq_fifo2 #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .flush_i     (cs_rise),
      .in_valid_i  (push),
      .in_data_i   (mem_rsp_i.data),
      .in_ready_o  (fifo_in_ready),
      .out_valid_o (fifo_out_valid),
      .out_data_o  (fifo_out_data),
      .out_ready_i (pop)
   );

   assign io_o                   = io_reg;
   assign io_oe_o                = oe_reg;
   assign mem_req_o              = req_reg;
   assign mem_addr_o             = maddr_reg;
   assign continuous_read_mode_o = cont_reg;
   assign reading_o              = reading_reg;

endmodule

// ===== sfq_read_engine_sva.sv
// Port checker for the flash read engine
`timescale 1ns/100ps
module sfq_read_engine_chk #(
   parameter int ADDR_W = 32
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              sys_rst_i,
   // Watched ports
   input  wire logic              cs_n_i,
   input  wire logic [3:0]        io_oe_o,
   input  wire logic              mem_req_o,
   input  wire logic [ADDR_W-1:0] mem_addr_o,
   input  wire logic              continuous_read_mode_o,
   input  wire logic              reading_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [ADDR_W-1:0] nxt_reg;
   logic              have_reg;
   // Chain forgotten at deselect, so a new start address is free
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
      if (sys_rst_i) have_reg <= 1'b0;
      else have_reg <= !cs_n_i && (have_reg || mem_req_o);
   always_ff @(posedge sys_clk_i)
      if (mem_req_o) nxt_reg <= mem_addr_o + 1'b1;
   property p_req_gap; mem_req_o |=> !mem_req_o [*2]; endproperty
   a_req_gap: assert property (p_req_gap)
      else $error("fetch gap");
   property p_addr_hold; !mem_req_o |-> $stable(mem_addr_o); endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("fetch address moved");
   property p_addr_inc; mem_req_o && have_reg |-> mem_addr_o == nxt_reg;
   endproperty
   a_addr_inc: assert property (p_addr_inc)
      else $error("fetch address not next byte");
   property p_oe_legal; io_oe_o inside {4'h0, 4'h2, 4'hf}; endproperty
   a_oe_legal: assert property (p_oe_legal)
      else $error("bad enable pattern");
   property p_desel_oe; $rose(cs_n_i) |-> ##[1:6] io_oe_o == 4'h0; endproperty
   a_desel_oe: assert property (p_desel_oe)
      else $error("lines driven after deselect");
   property p_idle_quiet; cs_n_i [*6] |-> !reading_o && io_oe_o == 4'h0;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("busy while deselected");
   property p_idle_nofetch; cs_n_i [*8] |-> !mem_req_o; endproperty
   a_idle_nofetch: assert property (p_idle_nofetch)
      else $error("fetch while deselected");
   property p_oe_in_frame; $rose(io_oe_o != 4'h0) |-> !$past(cs_n_i, 3);
   endproperty
   a_oe_in_frame: assert property (p_oe_in_frame)
      else $error("drive outside frame");
   c_single: cover property (io_oe_o == 4'h2);
   c_quad: cover property (io_oe_o == 4'hf);
   c_cont: cover property ($rose(continuous_read_mode_o));
endmodule
bind sfq_read_engine sfq_read_engine_chk #(.ADDR_W(ADDR_W)) i_chk (
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
   .io_oe_o(io_oe_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
   .continuous_read_mode_o(continuous_read_mode_o), .reading_o(reading_o));

// ===== sfq_host.sv
// Host controller model for the serial flash link
`timescale 1ns/100ps
module sfq_host (
   // Link pins
   output logic            sck_o,
   output logic            cs_n_o,
   output logic [3:0]      io_o,
   output logic            oe_o,
   input  wire logic [3:0] io_i
);
   initial {sck_o, cs_n_o, io_o, oe_o} = 7'h20;
   // one item per rising edge, clock still between frames
   task automatic clk(input logic [3:0] v, output logic [3:0] s);
      io_o = v;
      #80 sck_o = 1'b1;
      #80 s = io_i;
      sck_o = 1'b0;
   endtask
   // select moves only outside mode and dummies
   task automatic sel(input logic v);
      #165 cs_n_o = v;
   endtask
   task automatic send(input logic [31:0] v, input int n, input bit q);
      logic [3:0] s;
      oe_o = 1'b1;
      for (int k = n - (q ? 4 : 1); k >= 0; k -= (q ? 4 : 1))
         clk(q ? v[k+:4] : {~io_o[3:1], v[k]}, s);
   endtask
   // released lines show a changing pattern
   task automatic idle(input int n);
      logic [3:0] s;
      oe_o = 1'b0;
      repeat (n) clk(~io_o, s);
   endtask
   task automatic get(input bit q, output logic [7:0] b);
      logic [3:0] s;
      for (int k = 0; k < (q ? 2 : 8); k++) begin
         clk(~io_o, s);
         b = q ? {b[3:0], s} : {b[6:0], s[1]};
      end
   endtask
endmodule

// ===== tb_serial_flash_fast_quad_read.sv
// Self-checking bench for the flash read engine
`timescale 1ns/100ps
module tb_serial_flash_fast_quad_read;
   logic              sys_clk_i, sys_rst_i, sck, cs_n, h_oe, mem_req, cont;
   logic [3:0]        h_io, d_io, d_oe, io_w;
   logic [31:0]       mem_addr;
   logic [7:0]        b;
   sfq_pkg::sfq_cfg_t cfg;
   sfq_pkg::sfq_rsp_t rsp;
   int                errors, cmp_count;
   assign io_w = (d_oe & d_io) | (~d_oe & (h_oe ? h_io : ~h_io));
   sfq_host i_host (.sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .oe_o(h_oe),
      .io_i(io_w));
   sfq_read_engine i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .sck_i(sck), .cs_n_i(cs_n), .io_i(io_w), .io_o(d_io), .io_oe_o(d_oe),
      .cfg_i(cfg), .mem_req_o(mem_req), .mem_addr_o(mem_addr),
      .mem_rsp_i(rsp), .continuous_read_mode_o(cont), .reading_o());
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [7:0] exp_b(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   always @(posedge sys_clk_i) rsp <= {mem_req, exp_b(mem_addr)};
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp4(input logic [3:0] g, input logic [3:0] e);
      cmp8({4'h0, g}, {4'h0, e});
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Mode bits, then random latency code
   task automatic cf(input logic [3:0] m);
      @(posedge sys_clk_i);
      cfg <= {m, 4'($urandom_range(15, 0))};
      @(posedge sys_clk_i);
   endtask
   // Flags: cmd quad, no opcode, 4-byte, addr quad, mode, data quad, ok
   task automatic frame(input logic [7:0] op, input logic [6:0] f,
         input logic [31:0] a, input logic [7:0] md);
      logic [31:0] ea;
      logic [3:0]  oe;
      ea = f[4] ? a : {8'h00, a[23:0]};
      oe = 4'h0;
      i_host.sel(1'b0);
      if (!f[5]) i_host.send({24'h0, op}, 8, f[6]);
      i_host.send(ea, f[4] ? 32 : 24, f[3]);
      if (f[2]) i_host.send({24'h0, md}, 8, f[3]);
      i_host.idle(cfg.latency);
      for (int k = 0; k < 3; k++) begin
         i_host.get(f[1], b);
         oe |= d_oe;
         if (f[0]) cmp8(b, exp_b(ea + k));
      end
      cmp4(oe, f[0] ? (f[1] ? 4'hf : 4'h2) : 4'h0);
      i_host.sel(1'b1);
      repeat (8) @(posedge sys_clk_i);
      $display("frame %h done", op);
   endtask
   initial begin
      #1000000;
      errors++;
      finish_test();
   end
   initial begin
      void'($urandom(40143));
      sys_rst_i = 1'b1;
      cfg = '0;
      rsp = '0;
      errors = 0;
      cmp_count = 0;
      repeat (8) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      cf(4'h2);
      frame(8'h0b, 7'h05, $urandom, 8'h0a);
      cf(4'h3);
      frame(8'h0b, 7'h15, $urandom, 8'h00);
      frame(8'h6b, 7'h13, $urandom, 8'h00);
      cf(4'h2);
      frame(8'h0c, 7'h15, $urandom, 8'h00);
      frame(8'h6c, 7'h13, $urandom, 8'h00);
      frame(8'h6b, 7'h03, $urandom, 8'h00);
      frame(8'heb, 7'h0f, $urandom, 8'ha0);
      cmp4({3'h0, cont}, 4'h1);
      // release code in place of an address
      i_host.sel(1'b0);
      i_host.send(32'hff, 8, 1'b1);
      i_host.sel(1'b1);
      repeat (8) @(posedge sys_clk_i);
      cmp4({3'h0, cont}, 4'h0);
      $display("release done");
      frame(8'hec, 7'h1f, 32'hffff_ffff, 8'h00);
      frame(8'heb, 7'h0f, $urandom, 8'ha5);
      cmp4({3'h0, cont}, 4'h1);
      frame(8'h00, 7'h2f, $urandom, 8'h3a);
      cmp4({3'h0, cont}, 4'h0);
      cf(4'h0);
      frame(8'h6b, 7'h02, $urandom, 8'h00);
      frame(8'heb, 7'h0e, $urandom, 8'h00);
      cf(4'h4);
      frame(8'heb, 7'h0f, $urandom, 8'h00);
      cf(4'ha);
      frame(8'h6b, 7'h4a, $urandom, 8'h00);
      frame(8'heb, 7'h4f, $urandom, 8'h00);
      frame(8'hec, 7'h5f, $urandom, 8'h00);
      finish_test();
   end
endmodule
